// >>> mmcr_defs.vh
// Purpose: constants for the memory management control register block
// Assumes: APB byte addresses, 32-bit aligned words
// Notes: every offset and write mask, and the control and re-fetch field positions, live here
// Behaviour
// [RL1] Exception or address error captures whole faulting virtual address; software may rewrite.
// [RL2] Table base register holds last software value; hardware never changes it.
// [RL3] Age field resets zero; entry use writes its pattern, x bits kept.
// [RL4] Instruction TLB miss picks refill entry from age field patterns.
// [RL5] Software never writes an age pattern matching no refill pattern.
// [RL6] Victim counter increments per unified TLB access, not on load-entry.
// [RL7] Nonzero wrap limit clears counter on equality; above limit runs to 3f.
// [RL8] Store queue privilege bit set makes user access raise address error.
// [RL9] Single space bit selects single or multiple virtual memory comparison.
// [RL10] Software changing single space bit also writes flush bit.
// [RL11] Extended select bit picks mode; changing it needs flush of both TLBs.
// [RL12] Flush bit write clears all valid bits; flush bit reads zero.
// [RL13] Mapping enable zero disables translation and all MMU exceptions.
// [RL14] Software syncs by exception return, block invalidate or automatic re-fetch.
// [RL15] Software rewrites control register only from untranslated kernel regions.
// [RL16] Assist register holds six-bit rights and four-bit size; reserved reads zero.
// [RL17] Write-wait bit one stalls CPU until write ends; one bit per region.
// [RL18] Write-wait bit 7 is control register region, bits 6..0 areas 6..0.
// [RL19] Inhibit 2 zero forces re-fetch after control register change.
// [RL20] Inhibit 1 zero forces re-fetch after write to the register window.
// [RL21] Load-entry, table write and icache write inhibits suppress re-fetch when one.
// [RL22] Legacy size and protection bits apply only in compatible mode.
// [RL23] Load-entry copies page number and process id into the unified TLB.
// [RL24] Unified TLB has 64 entries indexed by counter and wrap limit.
// [RL25] Instruction TLB has four entries tracked by age field.
// [RL26] Reserved bits read zero and writes to them do nothing.
// [RL27] Hardware age and counter updates win over a same-cycle software write.
`ifndef MMCR_DEFS_VH
`define MMCR_DEFS_VH
`define MMCR_OFS_PTE_HIGH 12'h000
`define MMCR_OFS_PTE_LOW 12'h004
`define MMCR_OFS_TABLE_BASE 12'h008
`define MMCR_OFS_FAULT 12'h00c
`define MMCR_OFS_CTRL 12'h010
`define MMCR_OFS_ASSIST 12'h034
`define MMCR_OFS_PHYS 12'h070
`define MMCR_OFS_REFETCH 12'h078
`define MMCR_CTRL_MASK 32'hfcfcff85
`define MMCR_PAGE_ENTRY_HIGH_REG_MASK 32'hfffffcff
`define MMCR_PAGE_ENTRY_LOW_REG_MASK 32'h1ffffdff
`define MMCR_ASSIST_MASK 32'h00003ff0
`define MMCR_PHYS_MASK 32'h000000ff
`define MMCR_REFETCH_MASK 32'h0000001f
`define MMCR_AGE_HI 31
`define MMCR_AGE_LO 26
`define MMCR_WRAP_HI 23
`define MMCR_WRAP_LO 18
`define MMCR_CNT_HI 15
`define MMCR_CNT_LO 10
`define MMCR_SQ_BIT 9
`define MMCR_SV_BIT 8
`define MMCR_ME_BIT 7
`define MMCR_TI_BIT 2
`define MMCR_AT_BIT 0
`define MMCR_RF_R2 4
`define MMCR_RF_R1 3
`define MMCR_RF_LT 2
`define MMCR_RF_MT 1
`define MMCR_RF_MC 0
`define MMCR_CNT_MAX 6'h3f
`define MMCR_WIN_BASE 32'hff200000
`define MMCR_WIN_TOP 32'hff2fffff
`endif

// >>> mmcr_age.v
// Purpose: instruction TLB age field update and refill victim choice
// Assumes: at most one entry use per cycle
// Notes: pure combinational, the parent holds the age bits
`timescale 1ns/1ps
`default_nettype none
module mmcr_age (
  // Current age field
  input wire [5:0] age,
  // Entry use event
  input wire use_valid,
  input wire [1:0] use_entry,
  // Updated field and refill choice
  output reg [5:0] age_next,
  output reg [1:0] victim,
  output reg victim_ok
);
  // Pattern writes, x bits kept
  always @*
  begin
    age_next = age;
    if (use_valid)
    begin
      case (use_entry)
        2'd0: age_next = {3'b000, age[2:0]}; // [RL3]
        2'd1: age_next = {1'b1, age[4:3], 2'b00, age[0]}; // [RL3]
        2'd2: age_next = {age[5], 1'b1, age[3], 1'b1, age[1], 1'b0}; // [RL3]
        default: age_next = {age[5:4], 1'b1, age[2], 2'b11}; // [RL3]
      endcase
    end
  end
  // Refill choice; prohibited patterns flag not ok and fall to entry 0
  always @*
  begin
    victim = 2'd0;
    victim_ok = 1'b1;
    if (age[5:3] == 3'b111)
      victim = 2'd0; // [RL4]
    else if (!age[5] && age[2] && age[1])
      victim = 2'd1; // [RL4]
    else if (!age[4] && !age[2] && age[0])
      victim = 2'd2; // [RL4]
    else if (!age[3] && !age[1] && !age[0])
      victim = 2'd3; // [RL4]
    else
      victim_ok = 1'b0; // [RL5]
  end
endmodule
`default_nettype wire

// >>> mmcr_top.v
// Purpose: MMU control and status registers on APB with TLB side events
// Assumes: core events are single-cycle pulses synchronous to pclk
// Notes: zero wait state slave, unmapped addresses answer with pslverr
`timescale 1ns/1ps
`default_nettype none
`include "mmcr_defs.vh"
module mmcr_top #(
  parameter UNIFIED_TLB_ENTRIES = 64,
  parameter INSTR_TLB_ENTRIES = 4
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Exception capture
  input wire exc_valid,
  input wire [31:0] exc_vaddr,
  // TLB events from the core
  input wire unified_tlb_access,
  input wire load_entry_exec,
  input wire instr_tlb_use_valid,
  input wire [1:0] instr_tlb_use_entry,
  input wire instr_tlb_miss,
  // Store queue and window access checks
  input wire sq_access,
  input wire user_mode,
  input wire core_write,
  input wire [31:0] core_waddr,
  input wire core_uncached_write,
  input wire tlb_table_write,
  input wire icache_write,
  input wire icache_enable,
  input wire other_ctrl_change,
  // Outputs to TLB arrays and pipeline
  output reg mapping_enable,
  output reg single_space_mode,
  output reg extended_tlb_select,
  output reg flush_all_entries,
  output reg [5:0] unified_tlb_load_index,
  output reg [1:0] instr_tlb_refill_entry,
  output reg instr_tlb_refill_valid,
  output reg unified_tlb_load_strobe,
  output reg [21:0] unified_tlb_load_vpn,
  output reg [7:0] unified_tlb_load_asid,
  output reg [5:0] unified_tlb_load_rights,
  output reg [3:0] unified_tlb_load_size,
  output reg [1:0] unified_tlb_load_legacy_size,
  output reg [1:0] unified_tlb_load_legacy_prot,
  output reg sq_addr_error,
  output reg refetch_req,
  output reg write_wait_stall
);
  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  reg [31:0] page_entry_high_reg;
  reg [31:0] page_entry_low_reg;
  reg [31:0] table_base_reg;
  reg [31:0] fault_vaddr_reg;
  reg [31:0] mmu_control_reg;
  reg [31:0] page_entry_assist_reg;
  reg [31:0] phys_space_control_reg;
  reg [31:0] refetch_inhibit_reg;
  reg [31:0] mmu_control_next;
  reg [31:0] rdata_next;
  reg hit;
  wire wr_en;
  wire rd_en;
  wire [5:0] age_next;
  wire [1:0] victim;
  wire victim_ok;
  wire [5:0] instr_tlb_age_order;
  wire [5:0] unified_tlb_wrap_limit;
  wire [5:0] unified_tlb_victim_counter;
  wire [1:0] region;
  wire ctrl_wr;
  wire win_wr;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign instr_tlb_age_order = mmu_control_reg[`MMCR_AGE_HI:`MMCR_AGE_LO];
  assign unified_tlb_wrap_limit = mmu_control_reg[`MMCR_WRAP_HI:`MMCR_WRAP_LO];
  assign unified_tlb_victim_counter = mmu_control_reg[`MMCR_CNT_HI:`MMCR_CNT_LO];
  assign ctrl_wr = wr_en && (paddr == `MMCR_OFS_CTRL);
  assign win_wr = core_write && (core_waddr >= `MMCR_WIN_BASE) && (core_waddr <= `MMCR_WIN_TOP);
  assign region = core_waddr[27:26];

  // ---------------------------------------------------------------
  // Age field helper
  // ---------------------------------------------------------------
  mmcr_age u_age (
    .age(instr_tlb_age_order),
    .use_valid(instr_tlb_use_valid),
    .use_entry(instr_tlb_use_entry),
    .age_next(age_next),
    .victim(victim),
    .victim_ok(victim_ok)
  );

  // ---------------------------------------------------------------
  // Control register next value
  // ---------------------------------------------------------------
  // Software write first, hardware fields overlaid after so they win
  always @*
  begin
    mmu_control_next = mmu_control_reg;
    if (ctrl_wr)
      mmu_control_next = pwdata & `MMCR_CTRL_MASK; // [RL26]
    mmu_control_next[`MMCR_TI_BIT] = 1'b0; // [RL12]
    if (instr_tlb_use_valid)
      mmu_control_next[`MMCR_AGE_HI:`MMCR_AGE_LO] = age_next; // [RL27] [RL3]
    if (unified_tlb_access && !load_entry_exec) // [RL6] [RL27]
    begin
      if (unified_tlb_wrap_limit != 6'h00 && unified_tlb_victim_counter == unified_tlb_wrap_limit)
        mmu_control_next[`MMCR_CNT_HI:`MMCR_CNT_LO] = 6'h00; // [RL7]
      else if (unified_tlb_victim_counter == `MMCR_CNT_MAX)
        mmu_control_next[`MMCR_CNT_HI:`MMCR_CNT_LO] = 6'h00; // [RL7] [RL24]
      else
        mmu_control_next[`MMCR_CNT_HI:`MMCR_CNT_LO] = unified_tlb_victim_counter + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  always @*
  begin
    rdata_next = 32'h00000000;
    hit = 1'b1;
    if (paddr == `MMCR_OFS_PTE_HIGH)
      rdata_next = page_entry_high_reg;
    else if (paddr == `MMCR_OFS_PTE_LOW)
      rdata_next = page_entry_low_reg;
    else if (paddr == `MMCR_OFS_TABLE_BASE)
      rdata_next = table_base_reg;
    else if (paddr == `MMCR_OFS_FAULT)
      rdata_next = fault_vaddr_reg;
    else if (paddr == `MMCR_OFS_CTRL)
      rdata_next = mmu_control_reg & ~(32'h1 << `MMCR_TI_BIT); // [RL12]
    else if (paddr == `MMCR_OFS_ASSIST)
      rdata_next = page_entry_assist_reg; // [RL16]
    else if (paddr == `MMCR_OFS_PHYS)
      rdata_next = phys_space_control_reg;
    else if (paddr == `MMCR_OFS_REFETCH)
      rdata_next = refetch_inhibit_reg;
    else
      hit = 1'b0;
  end

  // ---------------------------------------------------------------
  // Registers and bus answer
  // ---------------------------------------------------------------
  // Single-cycle access phase keeps the bus simple; no wait states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      page_entry_high_reg <= 32'h00000000;
      page_entry_low_reg <= 32'h00000000;
      table_base_reg <= 32'h00000000;
      fault_vaddr_reg <= 32'h00000000;
      mmu_control_reg <= 32'h00000000; // [RL3]
      page_entry_assist_reg <= 32'h00000000;
      phys_space_control_reg <= 32'h00000000;
      refetch_inhibit_reg <= 32'h00000000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      mmu_control_reg <= mmu_control_next;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd_en && pready)
        prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
        prdata <= rdata_next;
      if (wr_en && pready)
      begin
        if (paddr == `MMCR_OFS_PTE_HIGH)
          page_entry_high_reg <= pwdata & `MMCR_PAGE_ENTRY_HIGH_REG_MASK;
        else if (paddr == `MMCR_OFS_PTE_LOW)
          page_entry_low_reg <= pwdata & `MMCR_PAGE_ENTRY_LOW_REG_MASK;
        else if (paddr == `MMCR_OFS_TABLE_BASE)
          table_base_reg <= pwdata; // [RL2]
        else if (paddr == `MMCR_OFS_ASSIST)
          page_entry_assist_reg <= pwdata & `MMCR_ASSIST_MASK; // [RL16] [RL26]
        else if (paddr == `MMCR_OFS_PHYS)
          phys_space_control_reg <= pwdata & `MMCR_PHYS_MASK; // [RL26]
        else if (paddr == `MMCR_OFS_REFETCH)
          refetch_inhibit_reg <= pwdata & `MMCR_REFETCH_MASK; // [RL26]
      end
      // Hardware capture wins over a same-cycle write to these
      if (exc_valid)
      begin
        fault_vaddr_reg <= exc_vaddr; // [RL1]
        page_entry_high_reg[31:10] <= exc_vaddr[31:10];
      end
      else if (wr_en && pready && paddr == `MMCR_OFS_FAULT)
        fault_vaddr_reg <= pwdata; // [RL1]
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the core and TLB arrays
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mapping_enable <= 1'b0;
      single_space_mode <= 1'b0;
      extended_tlb_select <= 1'b0;
      flush_all_entries <= 1'b0;
      unified_tlb_load_index <= 6'h00;
      instr_tlb_refill_entry <= 2'd0;
      instr_tlb_refill_valid <= 1'b0;
      unified_tlb_load_strobe <= 1'b0;
      unified_tlb_load_vpn <= 22'h000000;
      unified_tlb_load_asid <= 8'h00;
      unified_tlb_load_rights <= 6'h00;
      unified_tlb_load_size <= 4'h0;
      unified_tlb_load_legacy_size <= 2'b00;
      unified_tlb_load_legacy_prot <= 2'b00;
      sq_addr_error <= 1'b0;
      refetch_req <= 1'b0;
      write_wait_stall <= 1'b0;
    end
    else
    begin
      mapping_enable <= mmu_control_next[`MMCR_AT_BIT]; // [RL13]
      single_space_mode <= mmu_control_next[`MMCR_SV_BIT]; // [RL9] [RL10]
      extended_tlb_select <= mmu_control_next[`MMCR_ME_BIT]; // [RL11]
      flush_all_entries <= ctrl_wr && pready && pwdata[`MMCR_TI_BIT]; // [RL12] [RL11]
      unified_tlb_load_index <= mmu_control_next[`MMCR_CNT_HI:`MMCR_CNT_LO]; // [RL24]
      // Refill only while translation is on, so no miss work when off
      instr_tlb_refill_valid <= instr_tlb_miss && victim_ok && mmu_control_reg[`MMCR_AT_BIT]; // [RL13] [RL25]
      instr_tlb_refill_entry <= victim; // [RL4]
      unified_tlb_load_strobe <= load_entry_exec; // [RL23]
      unified_tlb_load_vpn <= page_entry_high_reg[31:10]; // [RL23]
      unified_tlb_load_asid <= page_entry_high_reg[7:0]; // [RL23]
      unified_tlb_load_rights <= page_entry_assist_reg[13:8]; // [RL16]
      unified_tlb_load_size <= page_entry_assist_reg[7:4]; // [RL16]
      // Legacy fields forced to zero in extended mode
      if (mmu_control_reg[`MMCR_ME_BIT])
      begin
        unified_tlb_load_legacy_size <= 2'b00; // [RL22]
        unified_tlb_load_legacy_prot <= 2'b00; // [RL22]
      end
      else
      begin
        unified_tlb_load_legacy_size <= {page_entry_low_reg[7], page_entry_low_reg[4]}; // [RL22]
        unified_tlb_load_legacy_prot <= {page_entry_low_reg[6], page_entry_low_reg[5]}; // [RL22]
      end
      sq_addr_error <= sq_access && user_mode && mmu_control_reg[`MMCR_SQ_BIT]; // [RL8]
      // Area 7 is the control register region, hence bit 7
      if (core_waddr[28:26] == 3'b111)
        write_wait_stall <= core_uncached_write && phys_space_control_reg[7]; // [RL18] [RL17]
      else
        write_wait_stall <= core_uncached_write && phys_space_control_reg[{1'b0, region} | {core_waddr[28], 2'b00}]; // [RL17] [RL18]
      refetch_req <=
        ((ctrl_wr && pready || other_ctrl_change) && !refetch_inhibit_reg[`MMCR_RF_R2]) || // [RL19]
        (win_wr && !refetch_inhibit_reg[`MMCR_RF_R1]) || // [RL20]
        (load_entry_exec && !refetch_inhibit_reg[`MMCR_RF_LT]) || // [RL21]
        (tlb_table_write && mmu_control_reg[`MMCR_AT_BIT] && !refetch_inhibit_reg[`MMCR_RF_MT]) ||
        (icache_write && icache_enable && !refetch_inhibit_reg[`MMCR_RF_MC]); // [RL21]
    end
  end
endmodule
`default_nettype wire

// >>> mmcr_checker_assertions.sv
// Purpose: port-level checks on mmcr_top
// Assumes: one-cycle APB answer, registered outputs
// Notes: wrap limit is internal, so a step may also land on 0
`timescale 1ns/1ps
`default_nettype none
`include "mmcr_defs.vh"
module mmcr_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Core side
  input wire logic unified_tlb_access,
  input wire logic load_entry_exec,
  input wire logic instr_tlb_miss,
  input wire logic mapping_enable,
  input wire logic flush_all_entries,
  input wire logic instr_tlb_refill_valid,
  input wire logic unified_tlb_load_strobe,
  input wire logic [5:0] unified_tlb_load_index
);
  // ----------------------------------------
  // Control register accesses
  // ----------------------------------------
  wire acc = psel && penable && pready && paddr == `MMCR_OFS_CTRL;
  wire ctrl_wr = acc && pwrite;
  wire ctrl_rd = acc && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence flush_wr;
    ctrl_wr && pwdata[`MMCR_TI_BIT];
  endsequence
  sequence flush_out;
    flush_all_entries ##1 !flush_all_entries;
  endsequence
  // Flush is a one-cycle pulse tied to its write
  flush_pulse_a: assert property (flush_wr |=> flush_out) else $error("flush pulse");
  flush_cause_a: assert property (flush_all_entries |-> $past(ctrl_wr && pwdata[`MMCR_TI_BIT]))
    else $error("flush without write");
  // Flush bit and reserved bits never read back
  ctrl_read_a: assert property (ctrl_rd |-> (prdata & ~`MMCR_CTRL_MASK) == 0 && !prdata[2])
    else $error("control readback");
  mode_follow_a: assert property (ctrl_wr |=> mapping_enable == $past(pwdata[`MMCR_AT_BIT]))
    else $error("mapping enable");
  // Refill only after a miss with mapping on
  refill_gate_a: assert property (instr_tlb_miss && !mapping_enable |=> !instr_tlb_refill_valid)
    else $error("refill while off");
  refill_cause_a: assert property (instr_tlb_refill_valid |-> $past(instr_tlb_miss))
    else $error("refill without miss");
  load_strobe_a: assert property (load_entry_exec |=> unified_tlb_load_strobe)
    else $error("load strobe");
  // Counter steps by one or wraps, else holds
  count_step_a: assert property (unified_tlb_access && !load_entry_exec && !ctrl_wr |=>
    unified_tlb_load_index == $past(unified_tlb_load_index) + 6'h01 || unified_tlb_load_index == 6'h00)
    else $error("counter step");
  count_hold_a: assert property (!unified_tlb_access && !ctrl_wr |=> $stable(unified_tlb_load_index))
    else $error("counter moved");
endmodule
bind mmcr_top mmcr_checker mmcr_checker_inst (.*);
`default_nettype wire

// >>> mmcr_core_model.sv
// Purpose: core pipeline stand-in driving TLB events
// Assumes: one event per call, two clock edges each
// Notes: released address lines show the inverse value
`timescale 1ns/1ps
`default_nettype none
module mmcr_core_model (
  // Clock
  input wire logic pclk,
  // Events and levels
  output logic exc_valid,
  output logic [31:0] exc_vaddr,
  output logic unified_tlb_access,
  output logic load_entry_exec,
  output logic instr_tlb_use_valid,
  output logic [1:0] instr_tlb_use_entry,
  output logic instr_tlb_miss,
  output logic sq_access,
  output logic user_mode,
  output logic core_write,
  output logic [31:0] core_waddr,
  output logic core_uncached_write,
  output logic tlb_table_write,
  output logic icache_write,
  output logic icache_enable,
  output logic other_ctrl_change
);
  // Quiet at time zero
  initial
  begin
    {exc_valid, unified_tlb_access, load_entry_exec, instr_tlb_use_valid, instr_tlb_miss} = '0;
    {sq_access, user_mode, core_write, core_uncached_write, tlb_table_write} = '0;
    {icache_write, icache_enable, other_ctrl_change, instr_tlb_use_entry} = '0;
    exc_vaddr = '0;
    core_waddr = '0;
  end
  // One-cycle pulse of event k carrying v
  task automatic fire(input int k, input logic [31:0] v);
    @(posedge pclk);
    exc_vaddr <= v;
    core_waddr <= v;
    instr_tlb_use_entry <= v[1:0];
    case (k)
      0: exc_valid <= 1'b1;
      1: unified_tlb_access <= 1'b1;
      2: load_entry_exec <= 1'b1;
      3: instr_tlb_use_valid <= 1'b1;
      4: instr_tlb_miss <= 1'b1;
      5: core_write <= 1'b1;
      6: tlb_table_write <= 1'b1;
      7: icache_write <= 1'b1;
      default: other_ctrl_change <= 1'b1;
    endcase
    @(posedge pclk);
    {exc_valid, unified_tlb_access, load_entry_exec, instr_tlb_use_valid, instr_tlb_miss} <= '0;
    {core_write, tlb_table_write, icache_write, other_ctrl_change} <= '0;
    exc_vaddr <= ~v;
    core_waddr <= ~v;
    #1;
  endtask
  // Levels: store queue, user, uncached, icache on
  task automatic lv(input logic [3:0] l);
    @(posedge pclk);
    {sq_access, user_mode, core_uncached_write, icache_enable} <= l;
    @(posedge pclk);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Purpose: self-checking bench for mmcr_top
// Assumes: APB driven on rising edges, events from mmcr_core_model
// Notes: expectations come from local models of the fields
`timescale 1ns/1ps
`default_nettype none
`include "mmcr_defs.vh"
module tb;
  typedef struct packed {logic [11:0] a; logic [31:0] m; logic e;} mmcr_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, exc_vaddr, core_waddr, rd_v;
  logic exc_valid, unified_tlb_access, load_entry_exec, instr_tlb_use_valid, instr_tlb_miss, sq_access;
  logic user_mode, core_write, core_uncached_write, tlb_table_write, icache_write;
  logic icache_enable, other_ctrl_change, mapping_enable, single_space_mode;
  logic extended_tlb_select, flush_all_entries, instr_tlb_refill_valid, unified_tlb_load_strobe;
  logic sq_addr_error, refetch_req, write_wait_stall;
  logic [1:0] instr_tlb_use_entry, instr_tlb_refill_entry, unified_tlb_load_legacy_size, unified_tlb_load_legacy_prot;
  logic [5:0] unified_tlb_load_index, unified_tlb_load_rights, age, cnt;
  logic [21:0] unified_tlb_load_vpn;
  logic [7:0] unified_tlb_load_asid;
  logic [3:0] unified_tlb_load_size;
  logic [2:0] pk;
  int num_errors = 0;
  int check_count = 0;
  int src [5] = '{8, 5, 2, 6, 7};
  logic [31:0] dv [3] = '{32'h0, 32'hffffffff, 32'h5a5a5a5e};
  mmcr_row_t rows [9] = '{'{`MMCR_OFS_PTE_HIGH, `MMCR_PAGE_ENTRY_HIGH_REG_MASK, 0},
    '{`MMCR_OFS_PTE_LOW, `MMCR_PAGE_ENTRY_LOW_REG_MASK, 0}, '{`MMCR_OFS_TABLE_BASE, 32'hffffffff, 0},
    '{`MMCR_OFS_FAULT, 32'hffffffff, 0}, '{`MMCR_OFS_CTRL, `MMCR_CTRL_MASK & ~32'h4, 0},
    '{`MMCR_OFS_ASSIST, `MMCR_ASSIST_MASK, 0}, '{`MMCR_OFS_PHYS, `MMCR_PHYS_MASK, 0},
    '{`MMCR_OFS_REFETCH, `MMCR_REFETCH_MASK, 0}, '{12'h0fc, 32'h0, 1}};
  mmcr_top mmcr_top_inst (.*);
  mmcr_core_model mmcr_core_model_inst (.*);
  // 50 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Hang guard, far past the run length
  initial
  begin
    #400000;
    num_errors++;
    end_of_test();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // APB transfer held until pready is seen high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      num_errors++;
    rd_v = prdata;
    rd_e = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  task automatic ev(input int k, input logic [31:0] v);
    mmcr_core_model_inst.fire(k, v);
  endtask
  // Age field update and refill choice, as the rules give them
  function automatic logic [5:0] use_age(logic [5:0] g, logic [1:0] e);
    case (e)
      0: return {3'b000, g[2:0]};
      1: return {1'b1, g[4:3], 2'b00, g[0]};
      2: return {g[5], 1'b1, g[3], 1'b1, g[1], 1'b0};
      default: return {g[5:4], 1'b1, g[2], 2'b11};
    endcase
  endfunction
  function automatic logic [2:0] pick(logic [5:0] g);
    casez (g)
      6'b111???: return 3'b100;
      6'b0??11?: return 3'b101;
      6'b?0?0?1: return 3'b110;
      6'b??0?00: return 3'b111;
      default: return 3'b000;
    endcase
  endfunction
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then two write patterns per register
    for (int p = 0; p < 3; p++)
      for (int i = 0; i < 9; i++)
      begin
        if (p > 0)
          apb(rows[i].a, 1'b1, dv[p]);
        apb(rows[i].a, 1'b0, 32'h0);
        chk(rd_v, dv[p] & rows[i].m, "reg");
        chk(rd_e, rows[i].e, "err");
      end
    // Mid-run reset clears the age field
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(`MMCR_OFS_CTRL, 1'b1, 32'h1);
    age = 6'h00;
    for (int i = 0; i < 10; i++)
    begin
      ev(3, (i * 3) % 4);
      age = use_age(age, (i * 3) % 4);
      ev(4, 0);
      pk = pick(age);
      chk(instr_tlb_refill_valid, pk[2], "refill_v");
      chk(instr_tlb_refill_entry, pk[1:0], "refill_e");
      apb(`MMCR_OFS_CTRL, 1'b0, 32'h0);
      chk(rd_v[31:26], age, "age");
    end
    // Age written back with mapping off; a miss then gives no refill
    apb(`MMCR_OFS_CTRL, 1'b1, {age, 26'h0});
    ev(4, 0);
    chk(instr_tlb_refill_valid, 0, "refill_off");
    // Wrap limit 3 from 0, then from above the limit
    for (int s = 0; s < 2; s++)
    begin
      cnt = s ? 6'h3e : 6'h00;
      apb(`MMCR_OFS_CTRL, 1'b1, {8'h00, 6'h03, 2'b00, cnt, 10'h001});
      for (int i = 0; i < 5; i++)
      begin
        ev(1, 0);
        cnt = (cnt == 6'h03 || cnt == 6'h3f) ? 6'h00 : cnt + 6'h01;
        chk(unified_tlb_load_index, cnt, "count");
      end
    end
    // Load entry copies fields, legacy bits only in compatible mode
    apb(`MMCR_OFS_PTE_HIGH, 1'b1, 32'habcdec12);
    apb(`MMCR_OFS_ASSIST, 1'b1, 32'h00002a50);
    apb(`MMCR_OFS_PTE_LOW, 1'b1, 32'h000000f0);
    ev(2, 0);
    chk(unified_tlb_load_index, cnt, "count_load");
    chk({unified_tlb_load_vpn, unified_tlb_load_asid}, {22'h2af37b, 8'h12}, "vpn_asid");
    chk({unified_tlb_load_rights, unified_tlb_load_size}, {6'h2a, 4'h5}, "ext");
    chk({unified_tlb_load_legacy_size, unified_tlb_load_legacy_prot}, 4'hf, "legacy");
    chk(unified_tlb_load_strobe, 1, "load_strobe");
    // Mode change carries the flush bit with it
    apb(`MMCR_OFS_CTRL, 1'b1, 32'h85);
    chk(flush_all_entries, 1, "flush");
    chk(extended_tlb_select, 1, "ext_sel");
    chk(single_space_mode, 0, "sv_off");
    ev(2, 0);
    chk(flush_all_entries, 0, "flush_end");
    chk({unified_tlb_load_legacy_size, unified_tlb_load_legacy_prot}, 4'h0, "legacy_ext");
    // Exception capture into fault and page high
    ev(0, 32'h12345678);
    apb(`MMCR_OFS_FAULT, 1'b0, 32'h0);
    chk(rd_v, 32'h12345678, "fault");
    apb(`MMCR_OFS_PTE_HIGH, 1'b0, 32'h0);
    chk(rd_v[31:10], 22'h048d15, "vpn_exc");
    // Store queue privilege bit against user mode
    for (int i = 0; i < 4; i++)
    begin
      apb(`MMCR_OFS_CTRL, 1'b1, {22'h0, i[0], 9'h004});
      mmcr_core_model_inst.lv({1'b1, i[1], 2'b00});
      chk(sq_addr_error, i == 3, "sq");
    end
    // Each inhibit bit against its own source; the control change source
    // is other_ctrl_change, not an APB write to the control register
    apb(`MMCR_OFS_CTRL, 1'b1, 32'h105);
    chk(single_space_mode, 1, "sv_on");
    mmcr_core_model_inst.lv(4'b0001);
    for (int k = 0; k < 5; k++)
      for (int h = 0; h < 2; h++)
      begin
        apb(`MMCR_OFS_REFETCH, 1'b1, h ? (32'h10 >> k) : (32'h1f ^ (32'h10 >> k)));
        ev(src[k], 32'hff200010);
        chk(refetch_req, !h, "refetch");
      end
    // Region 7 waits, region 6 does not
    apb(`MMCR_OFS_PHYS, 1'b1, 32'h80);
    mmcr_core_model_inst.lv(4'b0010);
    ev(5, 32'h1c000000);
    chk(write_wait_stall, 1, "stall7");
    ev(5, 32'h18000000);
    chk(write_wait_stall, 0, "stall6");
    end_of_test();
  end
endmodule
`default_nettype wire
